// ---- status_pkg.sv ----
// shared constants, command codes and helpers for the status reporting block
package status_pkg;
   localparam int BYTE_W = 8; // width of every 488.2 status register
   localparam int EXT_W = 16; // width of the extended event path
   localparam logic [7:0] SER_RESET = 8'h80; // power-on flag set at start
   localparam logic [7:0] MASK_RESET = 8'h00; // enables start all disabled
   localparam logic [15:0] EXT_RESET = 16'h0000; // extended regs empty
   localparam logic [7:0] SRE_KEEP = 8'hbf; // summary position never stored
   localparam logic [7:0] ASCII_ONE = 8'h31; // reply to operation query
   // status byte bit positions
   localparam int SB_EAV = 2;
   localparam int SB_EES = 3;
   localparam int SB_MAV = 4;
   localparam int SB_ESB = 5;
   localparam int SB_RQS = 6;
   // standard event bit positions
   localparam int SE_OPC = 0;
   localparam int SE_QYE = 2;
   localparam int SE_DDE = 3;
   localparam int SE_EXE = 4;
   localparam int SE_CME = 5;
   localparam int SE_PON = 7;
   // self-test duration
   localparam int CLK_PERIOD_PS = 10000; // 100 MHz core clock
   localparam int ST_TIME_MS = 1000; // roughly one second
   localparam int ST_CYCLES = ST_TIME_MS * (1000000000 / CLK_PERIOD_PS);
   localparam logic [1:0] IDN_LAST = 2'h3; // four identity fields

   // decoded common commands as delivered by the parser
   typedef enum logic [3:0] {
      cmd_cls, cmd_ese, cmd_ese_q, cmd_esr_q, cmd_idn_q, cmd_opc,
      cmd_opc_q, cmd_opt_q, cmd_rst, cmd_sre, cmd_sre_q, cmd_stb_q,
      cmd_tst_q, cmd_wai, cmd_eese, cmd_eesr_q
   } cmd_t;

   // kind of value carried by a response beat
   typedef enum logic [2:0] {
      resp_num, resp_ascii, resp_none_word, resp_id_maker,
      resp_id_model, resp_id_serial, resp_id_fw
   } resp_t;

   // true for every command that produces a response
   function automatic logic is_query(input cmd_t c);
      is_query = (c == cmd_ese_q) || (c == cmd_esr_q) || (c == cmd_idn_q)
         || (c == cmd_opc_q) || (c == cmd_opt_q) || (c == cmd_sre_q)
         || (c == cmd_stb_q) || (c == cmd_tst_q) || (c == cmd_eesr_q);
   endfunction : is_query
endpackage : status_pkg

// ---- selftest_if.sv ----
// handshake between the command core and the self-test timer
`timescale 1ns/1ps
interface selftest_if;
   logic start; // one-cycle request to run the test
   logic fail_src; // external pass/fail level, sampled at the end
   logic done; // one-cycle pulse when the test has finished
   logic result; // 1 when the test failed
   modport ctrl(output start, output fail_src, input done, input result);
   modport timer(input start, input fail_src, output done, output result);
endinterface : selftest_if

// ---- self_test_timer.sv ----
// paces the self-test so that its answer comes after the full duration
`timescale 1ns/1ps
module self_test_timer #(
   parameter int unsigned TEST_CYCLES = status_pkg::ST_CYCLES
) (
   input wire logic core_clk_in, // core clock
   input wire logic nrst_in, // async reset, active low
   selftest_if.timer st // start in, done and result out
);
   logic [31:0] count_ff; // cycles elapsed in the running test
   logic busy_ff; // test in progress
   logic done_ff; // finished pulse
   logic result_ff; // captured outcome
   wire last_cycle = busy_ff && (count_ff == 32'(TEST_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////
   // count out the test; a start while busy is ignored
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         result_ff <= 1'b0;
      end else begin
         done_ff <= last_cycle; // R17
         if (st.start && !busy_ff) begin
            busy_ff <= 1'b1;
            count_ff <= '0;
         end else if (last_cycle) begin
            busy_ff <= 1'b0;
            result_ff <= st.fail_src; // R17
         end else if (busy_ff) begin
            count_ff <= count_ff + 32'h1;
         end
      end
   end

   assign st.done = done_ff;
   assign st.result = result_ff;
endmodule : self_test_timer

// ---- status_core.sv ----
// common command interpreter and status reporting registers
// What this block does
// R1 - clear-status zeroes event registers, error queue
// R2 - after terminator clear-status also empties output queue
// R3 - event enable takes 0..255, resets to zero
// R4 - disabled events never raise event summary bit
// R5 - event enable read returns value unchanged
// R6 - event register query returns sum then clears
// R7 - syntax error sets event bit five
// R8 - identity answers maker, model, serial, firmware
// R9 - operation-complete command sets bit zero immediately
// R10 - operation-complete query answers ASCII one at once
// R11 - options query answers none; later query errors
// R12 - reset command restores defaults except communication
// R13 - service enable takes 0..255, resets zero, readable
// R14 - service enable bit six stored as zero
// R15 - status query reports master summary in bit six
// R16 - status query clears nothing
// R17 - self-test answers 0 or 1 after one second
// R18 - wait command accepted, does nothing
// R19 - summary bits from events, output, extended, errors
// R20 - event and extended sources each gated by own enable mask
// R21 - serial poll returns status byte with request bit
// R22 - master summary when any enabled bit set
// R23 - request bit set on rise, cleared by poll/fall
// R24 - error-available bit follows error queue non-empty
// R25 - power-on bit set after reset
// R26 - summaries recomputed from current state every cycle
`timescale 1ns/1ps
module status_core #(
   parameter int unsigned TEST_CYCLES = status_pkg::ST_CYCLES,
   parameter logic [15:0] MAKER_CODE = 16'h00a5, // arbitrary value
   parameter logic [15:0] MODEL_CODE = 16'h0001, // arbitrary value
   parameter logic [15:0] SERIAL_NO = 16'h0001, // arbitrary value
   parameter logic [15:0] FW_VERSION = 16'h0100 // arbitrary value
) (
   input wire logic core_clk_in, // core clock
   input wire logic nrst_in, // async reset, active low
   input wire logic cmd_valid_in, // decoded command present
   input wire status_pkg::cmd_t cmd_in, // which common command
   input wire logic [15:0] cmd_arg_in, // numeric argument
   input wire logic msg_start_in, // command follows a terminator
   output logic cmd_ready_out, // core idle, can take a command this cycle
   input wire logic syntax_err_in, // parser saw a syntax error
   input wire logic exec_err_in, // command could not run
   input wire logic dev_err_in, // internal device fault
   input wire logic query_err_in, // output queue lost data
   input wire logic [15:0] ext_event_in, // filtered extended events
   input wire logic err_queue_nonempty_in, // error queue level
   input wire logic out_queue_nonempty_in, // output queue level
   input wire logic self_test_fail_in, // self-test outcome level
   input wire logic poll_in, // serial poll strobe
   output logic [7:0] poll_byte_out, // status byte for the poll
   output logic srq_out, // service request line
   output logic resp_valid_out, // response beat valid
   output status_pkg::resp_t resp_tag_out, // response kind
   output logic [15:0] resp_data_out, // response value
   output logic err_clear_out, // empty the error queue
   output logic out_clear_out, // empty the output queue
   output logic settings_reset_out // restore non-comm defaults
);
   typedef enum logic [1:0] {st_idle, st_idn, st_test} state_t;

   state_t state_ff; // sequencer state
   state_t nxt_state; // next sequencer state
   logic [7:0] ser_ff; // standard event flags
   logic [7:0] sem_ff; // standard event mask
   logic [7:0] srm_ff; // service request mask
   logic [15:0] eer_ff; // extended event register
   logic [15:0] eee_ff; // extended event enable
   logic rqs_ff; // request service latch
   logic mss_d_ff; // master summary one cycle ago
   logic opt_seen_ff; // options query already in this message
   logic [1:0] idn_idx_ff; // identity field being sent
   logic [7:0] poll_byte_ff; // captured poll answer
   logic resp_valid_ff; // response beat valid
   status_pkg::resp_t resp_tag_ff; // response kind
   logic [15:0] resp_data_ff; // response value
   logic err_clr_ff; // error-queue clear pulse
   logic out_clr_ff; // output-queue clear pulse
   logic rst_ff; // settings reset pulse
   logic nxt_valid; // next response valid
   status_pkg::resp_t nxt_tag; // next response kind
   logic [15:0] nxt_data; // next response value
   selftest_if st(); // link to the self-test timer

   // zero-extends an 8-bit register into the response word
   function automatic logic [15:0] widen(input logic [7:0] v);
      widen = {{(status_pkg::EXT_W - status_pkg::BYTE_W){1'b0}}, v};
   endfunction : widen

   ////////////////////////////////////////////////////////////////////////
   // command decode
   assign cmd_ready_out = (state_ff == st_idle); // R18
   wire take = cmd_valid_in && cmd_ready_out;
   wire do_cls = take && (cmd_in == status_pkg::cmd_cls);
   wire do_esr = take && (cmd_in == status_pkg::cmd_esr_q);
   wire do_eesr = take && (cmd_in == status_pkg::cmd_eesr_q);
   wire do_opc = take && (cmd_in == status_pkg::cmd_opc);
   wire do_ese = take && (cmd_in == status_pkg::cmd_ese);
   wire do_sre = take && (cmd_in == status_pkg::cmd_sre);
   wire do_eese = take && (cmd_in == status_pkg::cmd_eese);
   wire do_rst = take && (cmd_in == status_pkg::cmd_rst);
   wire do_opt = take && (cmd_in == status_pkg::cmd_opt_q);
   wire do_idn = take && (cmd_in == status_pkg::cmd_idn_q);
   wire do_tst = take && (cmd_in == status_pkg::cmd_tst_q);
   wire take_q = take && status_pkg::is_query(cmd_in);
   // a query later in the same message as the options query
   wire opt_follow = take_q && opt_seen_ff && !msg_start_in; // R11

   ////////////////////////////////////////////////////////////////////////
   // event sources and summary bits, all combinational from state
   logic [7:0] ev_set; // events arriving this cycle
   always_comb begin
      ev_set = '0;
      ev_set[status_pkg::SE_OPC] = do_opc; // R9
      ev_set[status_pkg::SE_QYE] = query_err_in | opt_follow; // R11
      ev_set[status_pkg::SE_DDE] = dev_err_in;
      ev_set[status_pkg::SE_EXE] = exec_err_in;
      ev_set[status_pkg::SE_CME] = syntax_err_in; // R7
   end
   // the set wins: an event landing with a clear or a read is kept
   wire [7:0] nxt_ser = ((do_cls || do_esr) ? '0 : ser_ff) | ev_set; // R1 R6
   wire [15:0] nxt_eer = ((do_cls || do_eesr) ? '0 : eer_ff)
      | ext_event_in; // R1
   wire esb = |(ser_ff & sem_ff); // R4 R20
   wire ees = |(eer_ff & eee_ff); // R20
   logic [7:0] stb_core; // status byte without bit 6
   always_comb begin
      stb_core = '0;
      stb_core[status_pkg::SB_EAV] = err_queue_nonempty_in; // R24
      stb_core[status_pkg::SB_EES] = ees; // R19
      stb_core[status_pkg::SB_MAV] = out_queue_nonempty_in; // R19
      stb_core[status_pkg::SB_ESB] = esb; // R19
   end
   wire mss = |(stb_core & srm_ff); // R22 R26
   wire [7:0] rqs_bit = rqs_ff ? (8'h01 << status_pkg::SB_RQS) : '0;
   wire [7:0] mss_bit = mss ? (8'h01 << status_pkg::SB_RQS) : '0;
   // rising summary sets, falling summary or poll clears; rise wins
   wire nxt_rqs = mss && ((!mss_d_ff) || (rqs_ff && !poll_in)); // R23

   ////////////////////////////////////////////////////////////////////////
   // sequencer: identity needs four beats, self-test waits for the timer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         st_idle: begin
            if (do_idn) begin
               nxt_state = st_idn;
            end else if (do_tst) begin
               nxt_state = st_test;
            end
         end
         st_idn: begin
            if (idn_idx_ff == status_pkg::IDN_LAST) begin
               nxt_state = st_idle;
            end
         end
         st_test: begin
            if (st.done) begin
               nxt_state = st_idle;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // response selection
   always_comb begin
      nxt_valid = 1'b0;
      nxt_tag = status_pkg::resp_num;
      nxt_data = '0;
      if (state_ff == st_idn) begin
         nxt_valid = 1'b1; // R8
         unique case (idn_idx_ff)
            2'h0: begin
               nxt_tag = status_pkg::resp_id_maker;
               nxt_data = MAKER_CODE;
            end
            2'h1: begin
               nxt_tag = status_pkg::resp_id_model;
               nxt_data = MODEL_CODE;
            end
            2'h2: begin
               nxt_tag = status_pkg::resp_id_serial;
               nxt_data = SERIAL_NO;
            end
            2'h3: begin
               nxt_tag = status_pkg::resp_id_fw;
               nxt_data = FW_VERSION;
            end
         endcase
      end else if (state_ff == st_test) begin
         nxt_valid = st.done; // R17
         nxt_data = {15'h0000, st.result}; // R17
      end else if (take_q && !do_idn && !do_tst) begin
         nxt_valid = 1'b1;
         unique case (cmd_in)
            status_pkg::cmd_ese_q: nxt_data = widen(sem_ff); // R5
            status_pkg::cmd_esr_q: nxt_data = widen(ser_ff); // R6
            status_pkg::cmd_sre_q: nxt_data = widen(srm_ff); // R13
            status_pkg::cmd_stb_q: nxt_data = widen(stb_core | mss_bit); // R15
            status_pkg::cmd_eesr_q: nxt_data = eer_ff;
            status_pkg::cmd_opc_q: begin
               nxt_tag = status_pkg::resp_ascii; // R10
               nxt_data = widen(status_pkg::ASCII_ONE); // R10
            end
            status_pkg::cmd_opt_q: nxt_tag = status_pkg::resp_none_word; // R11
            default: nxt_data = '0;
         endcase
      end
   end

   assign st.start = do_tst; // R17
   assign st.fail_src = self_test_fail_in;

   self_test_timer #(.TEST_CYCLES(TEST_CYCLES)) u_timer (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .st(st.timer)
   );

   ////////////////////////////////////////////////////////////////////////
   // status registers; wait command has no branch and so does nothing
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ser_ff <= status_pkg::SER_RESET; // R25
         sem_ff <= status_pkg::MASK_RESET; // R3
         srm_ff <= status_pkg::MASK_RESET; // R13
         eer_ff <= status_pkg::EXT_RESET;
         eee_ff <= status_pkg::EXT_RESET;
      end else begin
         ser_ff <= nxt_ser;
         eer_ff <= nxt_eer;
         if (do_ese) sem_ff <= cmd_arg_in[7:0]; // R3
         if (do_sre) srm_ff <= cmd_arg_in[7:0] & status_pkg::SRE_KEEP; // R14
         if (do_eese) eee_ff <= cmd_arg_in;
      end
   end

   // request latch, poll capture and message tracking
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rqs_ff <= 1'b0;
         mss_d_ff <= 1'b0;
         poll_byte_ff <= '0;
         opt_seen_ff <= 1'b0;
      end else begin
         rqs_ff <= nxt_rqs; // R23
         mss_d_ff <= mss;
         if (poll_in) poll_byte_ff <= stb_core | rqs_bit; // R21
         if (take) opt_seen_ff <= do_opt || (opt_seen_ff && !msg_start_in);
      end
   end

   // sequencer, responses and side-effect pulses
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_ff <= st_idle;
         idn_idx_ff <= '0;
         resp_valid_ff <= 1'b0;
         resp_tag_ff <= status_pkg::resp_num;
         resp_data_ff <= '0;
         err_clr_ff <= 1'b0;
         out_clr_ff <= 1'b0;
         rst_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         idn_idx_ff <= (state_ff == st_idn) ? idn_idx_ff + 2'h1 : '0;
         resp_valid_ff <= nxt_valid;
         resp_tag_ff <= nxt_tag;
         resp_data_ff <= nxt_data;
         err_clr_ff <= do_cls; // R1
         out_clr_ff <= do_cls && msg_start_in; // R2
         rst_ff <= do_rst; // R12
      end
   end

   assign poll_byte_out = poll_byte_ff;
   assign srq_out = rqs_ff;
   assign resp_valid_out = resp_valid_ff;
   assign resp_tag_out = resp_tag_ff;
   assign resp_data_out = resp_data_ff;
   assign err_clear_out = err_clr_ff;
   assign out_clear_out = out_clr_ff;
   assign settings_reset_out = rst_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks on the behaviour above
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   esr_clear_a: // R6
   assert property (do_esr && !(|ev_set) |=> ser_ff == '0 && resp_valid_out
      && resp_data_out == widen($past(ser_ff)))
      else $error("event query did not return and clear");
   cls_clear_a: // R1
   assert property (do_cls |=> eer_ff == $past(ext_event_in) && err_clear_out)
      else $error("clear-status missed a register or queue");
   outq_clear_a: // R2
   assert property (do_cls |=> out_clear_out == $past(msg_start_in))
      else $error("output queue clear does not follow terminator");
   esb_gate_a: // R4
   assert property ((ser_ff & sem_ff) == '0 |-> !stb_core[status_pkg::SB_ESB])
      else $error("masked event raised summary");
   sre_bit6_a: // R14
   assert property (do_sre |=> !srm_ff[status_pkg::SB_RQS]
      && srm_ff == ($past(cmd_arg_in[7:0]) & status_pkg::SRE_KEEP))
      else $error("service enable stored wrong value");
   opc_set_a: // R9
   assert property (do_opc |=> ser_ff[status_pkg::SE_OPC])
      else $error("operation complete bit not set");
   opc_query_a: // R10
   assert property (take && cmd_in == status_pkg::cmd_opc_q |=> resp_valid_out
      && resp_data_out == widen(status_pkg::ASCII_ONE))
      else $error("operation query did not answer one");
   rqs_rise_a: // R23
   assert property ($rose(mss) |=> srq_out)
      else $error("request not raised on summary rise");
   rqs_drop_a: // R23
   assert property (!mss |=> !srq_out)
      else $error("request held with summary low");
   stb_keep_a: // R16
   assert property (take && cmd_in == status_pkg::cmd_stb_q && !(|ev_set)
      && !poll_in |=> ser_ff == $past(ser_ff) && rqs_ff == $past(rqs_ff)
      && resp_data_out[status_pkg::SB_RQS] == $past(mss))
      else $error("status query had a side effect");
   idn_order_a: // R8
   assert property (do_idn |=> resp_tag_out == status_pkg::resp_num
      ##1 resp_tag_out == status_pkg::resp_id_maker
      ##1 resp_tag_out == status_pkg::resp_id_model
      ##1 resp_tag_out == status_pkg::resp_id_serial
      ##1 resp_tag_out == status_pkg::resp_id_fw)
      else $error("identity fields out of order");
   opt_follow_a: // R11
   assert property (opt_follow |=> ser_ff[status_pkg::SE_QYE])
      else $error("query after options not flagged");
endmodule : status_core

// ---- status_queue_model.sv ----
// far-side model of the error and output queues seen by the status block
`timescale 1ns/1ps
module status_queue_model (
   input wire logic core_clk_in, // core clock
   input wire logic nrst_in, // async reset, active low
   input wire logic err_push_in, // an error entry arrives
   input wire logic out_push_in, // a response is queued
   input wire logic err_clear_in, // block asks to empty errors
   input wire logic out_clear_in, // block asks to empty responses
   output logic err_level_out, // error queue holds an entry
   output logic out_level_out // output queue holds data
);
   ////////////////////////////////////////////////////////////////////
   // levels only: entry contents never reach the status block
   // clear wins over push so an emptied queue reads empty at once
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         err_level_out <= 1'b0;
         out_level_out <= 1'b0;
      end else begin
         if (err_clear_in) err_level_out <= 1'b0;
         else if (err_push_in) err_level_out <= 1'b1;
         if (out_clear_in) out_level_out <= 1'b0;
         else if (out_push_in) out_level_out <= 1'b1;
      end
   end
endmodule : status_queue_model

// ---- tb_status_core.sv ----
// self-checking bench for the status reporting block
`timescale 1ns/1ps
module tb_status_core;
   localparam logic [15:0] MK = 16'h005a; // arbitrary value
   logic clk = 1'b0, nrst = 1'b0, valid = 1'b0, start = 1'b0; // drives
   logic poll = 1'b0, fail = 1'b0, epush = 1'b0, opush = 1'b0; // drives
   status_pkg::cmd_t cmd = status_pkg::cmd_wai; // command code
   logic [15:0] arg = 16'h0000, ext = 16'h0000; // argument, events
   logic [3:0] ev = 4'h0; // syntax, exec, device, query error pulses
   logic ready, srq, rv, errc, outc, rstp, eq, oq; // observed
   logic [7:0] pb; // poll byte
   status_pkg::resp_t tag; // response kind
   logic [15:0] rd; // response value
   int n_fail = 0, n_compared = 0;
   ////////////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   status_core #(.TEST_CYCLES(8), .MAKER_CODE(MK),
      .MODEL_CODE(MK + 16'h0001), .SERIAL_NO(MK + 16'h0002),
      .FW_VERSION(MK + 16'h0003)) i_status_core (
      .core_clk_in(clk), .nrst_in(nrst), .cmd_valid_in(valid),
      .cmd_in(cmd), .cmd_arg_in(arg), .msg_start_in(start),
      .cmd_ready_out(ready), .syntax_err_in(ev[0]), .exec_err_in(ev[1]),
      .dev_err_in(ev[2]), .query_err_in(ev[3]), .ext_event_in(ext),
      .err_queue_nonempty_in(eq), .out_queue_nonempty_in(oq),
      .self_test_fail_in(fail), .poll_in(poll), .poll_byte_out(pb),
      .srq_out(srq), .resp_valid_out(rv), .resp_tag_out(tag),
      .resp_data_out(rd), .err_clear_out(errc), .out_clear_out(outc),
      .settings_reset_out(rstp));
   status_queue_model i_status_queue_model (.core_clk_in(clk),
      .nrst_in(nrst), .err_push_in(epush), .out_push_in(opush),
      .err_clear_in(errc), .out_clear_in(outc), .err_level_out(eq),
      .out_level_out(oq));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_tag(status_pkg::resp_t e, status_pkg::resp_t g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] resp_tag expected %0d seen %0d", e, g);
      end
   endtask : chk_tag
   // hold the command until ready is seen, released after the take edge
   task automatic send(status_pkg::cmd_t c, logic [15:0] a, logic st);
      int k;
      @(posedge clk);
      valid <= 1'b1;
      cmd <= c;
      arg <= a;
      start <= st;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (ready !== 1'b1 && k < 20);
      @(posedge clk);
      valid <= 1'b0;
   endtask : send
   // wait a bounded span for one response beat, then judge its kind
   task automatic ans(status_pkg::resp_t t, int lim);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (rv !== 1'b1 && k < lim);
      chk("resp_valid", 16'h0001, {15'h0000, rv});
      chk_tag(t, tag);
   endtask : ans
   task automatic qn(status_pkg::cmd_t c, logic st, logic [15:0] d);
      send(c, 16'h0000, st);
      ans(status_pkg::resp_num, 4);
      chk("resp_data", d, rd);
   endtask : qn
   task automatic pulse(int k);
      @(posedge clk);
      ev[k] <= 1'b1;
      @(posedge clk);
      ev[k] <= 1'b0;
   endtask : pulse
   task automatic tally_and_finish();
      if (n_fail == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////
   // power-on contents, then a read that clears the event flags
   task automatic t_reset();
      qn(status_pkg::cmd_esr_q, 1'b1, 16'h0080);
      qn(status_pkg::cmd_esr_q, 1'b1, 16'h0000);
      qn(status_pkg::cmd_ese_q, 1'b1, 16'h0000);
      qn(status_pkg::cmd_sre_q, 1'b1, 16'h0000);
   endtask : t_reset
   // a masked event stays out of the summary; syntax error reads 32
   task automatic t_mask();
      send(status_pkg::cmd_ese, 16'h00fb, 1'b1);
      qn(status_pkg::cmd_ese_q, 1'b1, 16'h00fb);
      qn(status_pkg::cmd_ese_q, 1'b1, 16'h00fb);
      pulse(3);
      qn(status_pkg::cmd_stb_q, 1'b1, 16'h0000);
      qn(status_pkg::cmd_esr_q, 1'b1, 16'h0004);
      pulse(0);
      qn(status_pkg::cmd_esr_q, 1'b1, 16'h0020);
   endtask : t_mask
   // service request raised, read without side effect, cleared by poll
   task automatic t_srq();
      send(status_pkg::cmd_sre, 16'h00ef, 1'b1);
      qn(status_pkg::cmd_sre_q, 1'b1, 16'h00af);
      send(status_pkg::cmd_sre, 16'h0020, 1'b1);
      pulse(0);
      repeat (3) @(posedge clk);
      chk("srq", 16'h0001, {15'h0000, srq});
      qn(status_pkg::cmd_stb_q, 1'b1, 16'h0060);
      qn(status_pkg::cmd_stb_q, 1'b1, 16'h0060);
      @(posedge clk);
      poll <= 1'b1;
      @(posedge clk);
      poll <= 1'b0;
      @(negedge clk);
      chk("poll_byte", 16'h0060, {8'h00, pb});
      chk("srq", 16'h0000, {15'h0000, srq});
      qn(status_pkg::cmd_esr_q, 1'b1, 16'h0020);
      qn(status_pkg::cmd_stb_q, 1'b1, 16'h0000);
      send(status_pkg::cmd_sre, 16'h0000, 1'b1);
   endtask : t_srq
   // no overlapped work: completion flag set and answer given at once
   task automatic t_opc();
      send(status_pkg::cmd_opc, 16'h0000, 1'b1);
      qn(status_pkg::cmd_esr_q, 1'b1, 16'h0001);
      send(status_pkg::cmd_opc_q, 16'h0000, 1'b1);
      ans(status_pkg::resp_ascii, 2);
      chk("resp_data", 16'h0031, rd);
      send(status_pkg::cmd_wai, 16'h0000, 1'b1);
      repeat (3) @(negedge clk);
      chk("resp_valid", 16'h0000, {15'h0000, rv});
      qn(status_pkg::cmd_esr_q, 1'b1, 16'h0000);
   endtask : t_opc
   // extended event gated by its own enable into the summary
   task automatic t_ext();
      send(status_pkg::cmd_eese, 16'h0001, 1'b1);
      @(posedge clk);
      ext <= 16'h0001;
      @(posedge clk);
      ext <= 16'h0000;
      qn(status_pkg::cmd_stb_q, 1'b1, 16'h0008);
      qn(status_pkg::cmd_eesr_q, 1'b1, 16'h0001);
      qn(status_pkg::cmd_stb_q, 1'b1, 16'h0000);
   endtask : t_ext
   // clear-status keeps the output queue unless first in its message
   task automatic t_cls();
      @(posedge clk);
      epush <= 1'b1;
      opush <= 1'b1;
      @(posedge clk);
      epush <= 1'b0;
      opush <= 1'b0;
      pulse(0);
      qn(status_pkg::cmd_stb_q, 1'b1, 16'h0034);
      send(status_pkg::cmd_cls, 16'h0000, 1'b0);
      repeat (3) @(negedge clk);
      chk("err_queue", 16'h0000, {15'h0000, eq});
      chk("out_queue", 16'h0001, {15'h0000, oq});
      qn(status_pkg::cmd_esr_q, 1'b1, 16'h0000);
      send(status_pkg::cmd_cls, 16'h0000, 1'b1);
      repeat (3) @(negedge clk);
      chk("out_queue", 16'h0000, {15'h0000, oq});
   endtask : t_cls
   // identity in four beats, options answer, then a forbidden query
   task automatic t_idn_opt();
      send(status_pkg::cmd_idn_q, 16'h0000, 1'b1);
      ans(status_pkg::resp_id_maker, 4);
      chk("resp_data", MK, rd);
      ans(status_pkg::resp_id_model, 1);
      ans(status_pkg::resp_id_serial, 1);
      ans(status_pkg::resp_id_fw, 1);
      chk("resp_data", MK + 16'h0003, rd);
      send(status_pkg::cmd_opt_q, 16'h0000, 1'b1);
      ans(status_pkg::resp_none_word, 2);
      qn(status_pkg::cmd_stb_q, 1'b0, 16'h0000);
      qn(status_pkg::cmd_esr_q, 1'b1, 16'h0004);
   endtask : t_idn_opt
   // self-test pass and fail, then reset command keeps the event enable mask
   task automatic t_tst_rst();
      int k;
      for (k = 0; k < 2; k++) begin
         fail <= k[0];
         send(status_pkg::cmd_tst_q, 16'h0000, 1'b1);
         ans(status_pkg::resp_num, 16);
         chk("resp_data", {15'h0000, k[0]}, rd);
      end
      send(status_pkg::cmd_rst, 16'h0000, 1'b1);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (rstp !== 1'b1 && k < 4);
      chk("settings_reset", 16'h0001, {15'h0000, rstp});
      qn(status_pkg::cmd_ese_q, 1'b1, 16'h00fb);
   endtask : t_tst_rst
   ////////////////////////////////////////////////////////////////////
   // watchdog spans many times the expected few hundred cycles
   initial begin
      #200000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_mask();
      t_srq();
      t_opc();
      t_ext();
      t_cls();
      t_idn_opt();
      t_tst_rst();
      tally_and_finish();
   end
endmodule : tb_status_core
